/* rtl/auto_arm_pkg.sv */
// Constants, types and register map of the auto-arm recording sequencer.
// Assumes one 10 MHz core clock and a same-clock acquisition engine.
// Behaviour
// - Auto mode re-arms after each completed recording
// - Count completed recordings; report level and count
// - Level shows asterisk, then zero, each cycle
// - Hung condition halts, reports level, freezes count
// - Hung condition clearing resumes without resetting count
// - Missing external clock halts; resumes on return
// - Nonzero pass limit stops when count reaches it
// - Completion shows ready and holds count
// - Arm command clears count and restarts
// - Stop on first recording differing from reference
// - Stop on first recording matching reference
// - Setup writes accepted during running, no abort
package auto_arm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_CMD = 5'h04;
	localparam logic [4:0] OFS_LIMIT = 5'h08;
	localparam logic [4:0] OFS_COUNT = 5'h0C;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

	// Field positions
	localparam int CMD_ARM_BIT = 0;
	localparam int CMD_HALT_BIT = 1;
	localparam int STAT_STAR_BIT = 4;
	localparam int STAT_CODE_LSB = 5;
	localparam int IRQ_W = 4;
	localparam int IRQ_READY_BIT = 0;
	localparam int IRQ_HUNG_BIT = 1;
	localparam int IRQ_CLK_BIT = 2;
	localparam int IRQ_CMP_BIT = 3;

	// Reset values
	localparam logic [3:0] CTRL_RESET = 4'h1;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

	// Sample clock loss detection
	localparam int CORE_CLK_HZ = 10_000_000;
	localparam int CLK_LOSS_TIME_NS = 10_000;
	localparam int CLK_LOSS_CYC = CLK_LOSS_TIME_NS / (1_000_000_000 / CORE_CLK_HZ);

	// Stop-on-compare modes
	typedef enum logic [1:0] {
		STOP_NONE = 2'b00,
		STOP_DIFFER = 2'b01,
		STOP_EQUAL = 2'b10
	} stop_mode_e;

	// Sequencer states; code doubles as the reported trace status
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RUN = 3'b001,
		S_HUNG = 3'b010,
		S_NOCLK = 3'b011,
		S_READY = 3'b100
	} seq_state_e;

	typedef struct packed {
		logic clkInternal;
		stop_mode_e stopMode;
		logic autoMode;
	} ctrl_s;

	typedef struct packed {
		logic recDone;
		logic cmpDiffer;
		logic condHung;
		logic [3:0] level;
	} acq_s;

endpackage : auto_arm_pkg

/* rtl/auto_arm_record_sequencer.sv */
// Auto-arm recording sequencer with an Avalon-MM register slave.
// Assumes the acquisition engine runs on core_clk; the sample clock pin does not.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
module auto_arm_record_sequencer import auto_arm_pkg::*; #(
	parameter int COUNT_W = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Avalon-MM slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Acquisition engine
	input wire acq_s acq,
	input wire logic sampleClkPin,
	output logic armStart,
	output logic captureEn,
	// Interrupt
	output logic irq
);

	if (COUNT_W < 4 || COUNT_W > 16) begin : g_chk
		$error("COUNT_W must lie in 4..16");
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait state on every access
	logic wait_q;
	logic [31:0] rdData_q;
	ctrl_s ctrl_q;
	logic [COUNT_W-1:0] limit_q;
	logic [COUNT_W-1:0] count_q;
	logic [COUNT_W-1:0] count_d;
	logic [IRQ_W-1:0] irqStat_q;
	logic [IRQ_W-1:0] irqMask_q;
	logic [3:0] level_q;
	logic star_q;
	seq_state_e state_q;
	seq_state_e state_d;

	wire busReq = read | write;
	wire accept = busReq & ~wait_q;
	wire wrAcc = accept & write;
	wire rdAcc = accept & read;
	wire [31:0] laneMask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
	wire [31:0] ctrlMerged = ({28'h0000000, ctrl_q} & ~laneMask) | (writedata & laneMask);
	wire [31:0] limitMerged = ({{(32-COUNT_W){1'b0}}, limit_q} & ~laneMask) | (writedata & laneMask);
	wire [31:0] maskMerged = ({28'h0000000, irqMask_q} & ~laneMask) | (writedata & laneMask);
	wire wrCtrl = wrAcc & (address == OFS_CTRL);
	wire wrLimit = wrAcc & (address == OFS_LIMIT);
	wire wrMask = wrAcc & (address == OFS_IRQ_MASK);
	wire wrCmd = wrAcc & (address == OFS_CMD) & byteenable[0];
	wire armCmd = wrCmd & writedata[CMD_ARM_BIT];
	wire haltCmd = wrCmd & writedata[CMD_HALT_BIT] & ~writedata[CMD_ARM_BIT];
	wire rdIrqStat = rdAcc & (address == OFS_IRQ_STAT);
	wire [7:0] statusWord = {state_q, star_q, level_q};

	wire [31:0] rdMux =
		(address == OFS_CTRL) ? {28'h0000000, ctrl_q} :
		(address == OFS_LIMIT) ? {{(32-COUNT_W){1'b0}}, limit_q} :
		(address == OFS_COUNT) ? {{(32-COUNT_W){1'b0}}, count_q} :
		(address == OFS_STATUS) ? {24'h000000, statusWord} :
		(address == OFS_IRQ_STAT) ? {28'h0000000, irqStat_q} :
		(address == OFS_IRQ_MASK) ? {28'h0000000, irqMask_q} : 32'h00000000;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wait_q <= 1'b1;
			rdData_q <= 32'h00000000;
		end else begin
			wait_q <= ~(busReq & wait_q);
			if (busReq & wait_q) rdData_q <= rdMux;
		end
	end

	// Setup writes never touch the sequencer state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= ctrl_s'(CTRL_RESET);
			limit_q <= '0;
			irqMask_q <= IRQ_MASK_RESET;
		end else begin
			if (wrCtrl) ctrl_q <= ctrl_s'(ctrlMerged[3:0]);
			if (wrLimit) limit_q <= limitMerged[COUNT_W-1:0];
			if (wrMask) irqMask_q <= maskMerged[IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample clock presence: two-flop synchroniser, then edge detect
	localparam int LOSS_W = $clog2(CLK_LOSS_CYC + 1);
	logic clkMeta_q;
	logic clkSync_q;
	logic clkPrev_q;
	logic [LOSS_W-1:0] lossCnt_q;
	wire clkEdge = clkSync_q ^ clkPrev_q;
	wire lossFull = (lossCnt_q == LOSS_W'(CLK_LOSS_CYC));
	wire clkLost = lossFull & ~ctrl_q.clkInternal;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clkMeta_q <= 1'b0;
			clkSync_q <= 1'b0;
			clkPrev_q <= 1'b0;
			lossCnt_q <= '0;
		end else begin
			clkMeta_q <= sampleClkPin;
			clkSync_q <= clkMeta_q;
			clkPrev_q <= clkSync_q;
			if (clkEdge) lossCnt_q <= '0;
			else if (!lossFull) lossCnt_q <= lossCnt_q + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	// Compare result is only looked at on recDone, after the record is whole
	wire [COUNT_W-1:0] countInc = count_q + 1'b1;
	wire inRun = (state_q == S_RUN) & ~star_q;
	wire doneNow = inRun & acq.recDone & ~clkLost & ~acq.condHung;
	wire limitHit = (limit_q != '0) & (countInc == limit_q);
	wire differStop = (ctrl_q.stopMode == STOP_DIFFER) & acq.cmpDiffer;
	wire equalStop = (ctrl_q.stopMode == STOP_EQUAL) & ~acq.cmpDiffer;
	wire seqStop = limitHit | differStop | equalStop | ~ctrl_q.autoMode;
	wire contRearm = doneNow & ~seqStop & ~armCmd & ~haltCmd;
	wire resumeHung = (state_q == S_HUNG) & ~acq.condHung;
	wire resumeClk = (state_q == S_NOCLK) & ~clkLost;

	always_comb begin
		state_d = state_q;
		count_d = count_q;
		if (armCmd) begin
			state_d = S_RUN;
			count_d = '0;
		end else if (haltCmd) begin
			state_d = S_READY;
			// A recording that ends with the halt still counts
			if (doneNow) count_d = countInc;
		end else begin
			case (state_q)
				S_IDLE: state_d = S_IDLE;
				S_RUN: begin
					if (clkLost) state_d = S_NOCLK;
					else if (acq.condHung) state_d = S_HUNG;
					else if (doneNow) begin
						count_d = countInc;
						state_d = seqStop ? S_READY : S_RUN;
					end
				end
				S_HUNG: if (resumeHung) state_d = S_RUN;
				S_NOCLK: if (resumeClk) state_d = S_RUN;
				S_READY: state_d = S_READY;
				default: state_d = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			count_q <= '0;
			star_q <= 1'b0;
			level_q <= 4'h0;
			armStart <= 1'b0;
			captureEn <= 1'b0;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
			// Asterisk for one cycle between recordings, then level zero
			star_q <= contRearm;
			armStart <= armCmd | (star_q & (state_q == S_RUN)) | resumeClk;
			// Memory holds the last recording once stopped
			captureEn <= (state_d == S_RUN) & ~contRearm;
			if (contRearm | armCmd) level_q <= 4'h0;
			else if (state_q == S_RUN) level_q <= acq.level;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts: a read clears only the bits it returned; set wins
	wire [IRQ_W-1:0] irqEvt;
	assign irqEvt[IRQ_READY_BIT] = (state_d == S_READY) & (state_q != S_READY);
	assign irqEvt[IRQ_HUNG_BIT] = (state_d == S_HUNG) & (state_q != S_HUNG);
	assign irqEvt[IRQ_CLK_BIT] = (state_d == S_NOCLK) & (state_q != S_NOCLK);
	assign irqEvt[IRQ_CMP_BIT] = doneNow & (differStop | equalStop);
	// Bits set after the read data were latched must survive the clear
	wire [IRQ_W-1:0] irqRdClr = rdIrqStat ? rdData_q[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] irqStat_d = (irqStat_q & ~irqRdClr) | irqEvt;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irqStat_q <= '0;
			irq <= 1'b0;
		end else begin
			irqStat_q <= irqStat_d;
			irq <= |(irqStat_d & irqMask_q);
		end
	end

	assign readdata = rdData_q;
	assign waitrequest = wait_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_rearm_forever: assert property (@(posedge core_clk) disable iff (rst)
		contRearm |=> star_q ##1 armStart)
		else $error("auto re-arm did not restart a recording");
	a_count_step_done: assert property (@(posedge core_clk) disable iff (rst)
		doneNow && !armCmd && !haltCmd |=> count_q == $past(countInc))
		else $error("completed recording not counted");
	a_star_level_zero: assert property (@(posedge core_clk) disable iff (rst)
		contRearm |=> star_q && level_q == 4'h0 ##1 !star_q)
		else $error("level did not show asterisk then zero");
	a_hung_count_freeze: assert property (@(posedge core_clk) disable iff (rst)
		state_q == S_HUNG && !armCmd |-> !captureEn ##1 count_q == $past(count_q))
		else $error("count moved while hung");
	a_hung_resume_count: assert property (@(posedge core_clk) disable iff (rst)
		resumeHung && !armCmd && !haltCmd |=> state_q == S_RUN && count_q == $past(count_q))
		else $error("hung resume lost the count");
	a_clock_loss_halt: assert property (@(posedge core_clk) disable iff (rst)
		state_q == S_RUN && clkLost && !armCmd && !haltCmd |=> state_q == S_NOCLK)
		else $error("missing clock did not halt");
	a_limit_stop: assert property (@(posedge core_clk) disable iff (rst)
		doneNow && limitHit && !armCmd |=> state_q == S_READY && count_q == $past(limit_q))
		else $error("pass limit not honoured");
	a_ready_hold: assert property (@(posedge core_clk) disable iff (rst)
		state_q == S_READY && !armCmd |=> state_q == S_READY && count_q == $past(count_q))
		else $error("ready state lost the count");
	a_arm_clears: assert property (@(posedge core_clk) disable iff (rst)
		armCmd |=> count_q == '0 && state_q == S_RUN && armStart)
		else $error("arm command did not restart");
	a_differ_stop: assert property (@(posedge core_clk) disable iff (rst)
		doneNow && ctrl_q.stopMode == STOP_DIFFER && acq.cmpDiffer && !armCmd |=> state_q == S_READY)
		else $error("differing recording did not stop");
	a_equal_stop: assert property (@(posedge core_clk) disable iff (rst)
		doneNow && ctrl_q.stopMode == STOP_EQUAL && !acq.cmpDiffer && !armCmd |=> state_q == S_READY)
		else $error("matching recording did not stop");
	a_setup_no_abort: assert property (@(posedge core_clk) disable iff (rst)
		state_q == S_RUN && (wrCtrl || wrLimit) && !clkLost && !acq.condHung && !doneNow
		|=> state_q == S_RUN)
		else $error("setup write aborted the sequence");
	a_memory_frozen: assert property (@(posedge core_clk) disable iff (rst)
		state_q == S_READY |-> !captureEn)
		else $error("capture enabled after stop");
	a_capture_gap: assert property (@(posedge core_clk) disable iff (rst)
		star_q |-> !captureEn)
		else $error("capture enabled between recordings");
	a_hung_level_hold: assert property (@(posedge core_clk) disable iff (rst)
		state_q == S_HUNG && !armCmd |=> level_q == $past(level_q))
		else $error("stuck level changed while hung");
	a_noclk_no_capture: assert property (@(posedge core_clk) disable iff (rst)
		state_q == S_NOCLK |-> !captureEn)
		else $error("capture enabled without sample clock");
	a_clock_resume: assert property (@(posedge core_clk) disable iff (rst)
		resumeClk && !armCmd && !haltCmd |=> state_q == S_RUN && armStart)
		else $error("returning clock did not resume recording");
	a_wait_answer: assert property (@(posedge core_clk) disable iff (rst)
		busReq && wait_q |=> !wait_q)
		else $error("bus access not answered after one wait state");
	a_wait_single: assert property (@(posedge core_clk) disable iff (rst)
		!wait_q |=> wait_q)
		else $error("waitrequest low for more than one cycle");
	a_irq_masked_off: assert property (@(posedge core_clk) disable iff (rst)
		irqMask_q == '0 |=> !irq)
		else $error("interrupt raised with all sources masked");

endmodule : auto_arm_record_sequencer

/* verification/acq_target_model.sv */
// Model of the acquisition engine and the probed target.
// Assumes the sequencer's core_clk; recordings last 20 cycles.
module acq_target_model import auto_arm_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Sequencer side
	input wire logic armStart,
	input wire logic captureEn,
	output acq_s acq,
	output logic sampleClkPin,
	// Scenario control
	input wire logic hang,
	input wire logic differ,
	input wire logic clkOn
);
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////////////
	logic [5:0] left_q;
	logic [1:0] div_q;
	logic doneNow;
	// A hung level stalls the recording, so no completion is faked
	// No sample clock, no samples: the recording cannot progress
	assign doneNow = (left_q == 6'h01) && !hang && captureEn && clkOn;
	assign acq = '{recDone: doneNow, cmpDiffer: differ, condHung: hang, level: hang ? 4'h5 : 4'h0};
	// Pin stands still while unplugged
	assign sampleClkPin = div_q[1];
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			left_q <= 6'h00;
			div_q <= 2'h0;
		end else begin
			div_q <= clkOn ? div_q + 2'h1 : div_q;
			if (armStart) begin
				left_q <= 6'h14;
			end else if (left_q != 6'h00 && !hang && captureEn && clkOn) begin
				left_q <= left_q - 6'h01;
			end
		end
	end
endmodule : acq_target_model

/* verification/tb_top.sv */
// Self-checking bench of the auto-arm recording sequencer.
// Assumes the model above as the far side; registers over Avalon-MM.
module tb_top import auto_arm_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest, armStart, captureEn, irq, sampleClkPin;
	logic hang = 1'b0;
	logic differ = 1'b0;
	logic clkOn = 1'b1;
	acq_s acq;
	int fails = 0;
	int checked = 0;
	logic [31:0] v;
	always #50 core_clk = ~core_clk;
	auto_arm_record_sequencer dut (.core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
		.byteenable(4'hF), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .acq(acq),
		.sampleClkPin(sampleClkPin), .armStart(armStart), .captureEn(captureEn), .irq(irq));
	acq_target_model model (.core_clk(core_clk), .rst(rst), .armStart(armStart), .captureEn(captureEn), .acq(acq),
		.sampleClkPin(sampleClkPin), .hang(hang), .differ(differ), .clkOn(clkOn));
	////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (fails == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rv);
		int n;
		n = 0;
		@(posedge core_clk);
		address <= a;
		read <= rd;
		write <= !rd;
		writedata <= wd;
		do begin
			@(posedge core_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rv = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50) begin
			fails++;
			test_done();
		end
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b0, a, d, dummy);
	endtask : wr
	task automatic waitState(input logic [2:0] st);
		int n;
		n = 0;
		do begin
			bus(1'b1, OFS_STATUS, 32'h0, v);
			n++;
		end while (v[7:5] !== st && n < 300);
		if (n >= 300) begin
			fails++;
			test_done();
		end
	endtask : waitState
	////////////////////////////////////////////////////////////////////////
	task automatic tResetRegs();
		bus(1'b1, OFS_CTRL, 32'h0, v); chk(v, 32'h1);
		bus(1'b1, OFS_IRQ_MASK, 32'h0, v); chk(v, 32'h0);
		wr(OFS_COUNT, 32'h55);
		bus(1'b1, OFS_COUNT, 32'h0, v); chk(v, 32'h0);
		bus(1'b1, 5'h1C, 32'h0, v); chk(v, 32'h0);
	endtask : tResetRegs
	task automatic tLimit();
		wr(OFS_LIMIT, 32'h3);
		wr(OFS_CMD, 32'h1);
		bus(1'b1, OFS_COUNT, 32'h0, v); chk(v, 32'h0);
		wr(OFS_IRQ_MASK, 32'h1);
		wr(OFS_LIMIT, 32'h3);
		bus(1'b1, OFS_STATUS, 32'h0, v); chk({29'h0, v[7:5]}, 32'h1);
		waitState(3'h4);
		bus(1'b1, OFS_COUNT, 32'h0, v); chk(v, 32'h3);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, OFS_IRQ_STAT, 32'h0, v); chk(v, 32'h1);
		repeat (30) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, OFS_COUNT, 32'h0, v); chk(v, 32'h3);
	endtask : tLimit
	task automatic tHang();
		wr(OFS_LIMIT, 32'h0);
		wr(OFS_CMD, 32'h1);
		repeat (30) @(posedge core_clk);
		hang <= 1'b1;
		waitState(3'h2);
		chk({28'h0, v[3:0]}, 32'h5);
		repeat (40) @(posedge core_clk);
		bus(1'b1, OFS_COUNT, 32'h0, v); chk(v, 32'h1);
		hang <= 1'b0;
		waitState(3'h1);
		bus(1'b1, OFS_COUNT, 32'h0, v); chk(v, 32'h1);
		repeat (60) @(posedge core_clk);
		bus(1'b1, OFS_COUNT, 32'h0, v); chk({31'h0, v > 32'h1}, 32'h1);
		wr(OFS_CMD, 32'h2);
		waitState(3'h4);
	endtask : tHang
	task automatic tClock();
		wr(OFS_CMD, 32'h1);
		repeat (30) @(posedge core_clk);
		clkOn <= 1'b0;
		waitState(3'h3);
		repeat (40) @(posedge core_clk);
		bus(1'b1, OFS_COUNT, 32'h0, v); chk(v, 32'h1);
		clkOn <= 1'b1;
		repeat (80) @(posedge core_clk);
		bus(1'b1, OFS_COUNT, 32'h0, v); chk({31'h0, v > 32'h1}, 32'h1);
		wr(OFS_CTRL, 32'h9);
		clkOn <= 1'b0;
		repeat (150) @(posedge core_clk);
		bus(1'b1, OFS_STATUS, 32'h0, v); chk({29'h0, v[7:5]}, 32'h1);
		clkOn <= 1'b1;
		repeat (10) @(posedge core_clk);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CMD, 32'h2);
		waitState(3'h4);
	endtask : tClock
	task automatic tCompare();
		wr(OFS_CTRL, 32'h3);
		differ <= 1'b1;
		wr(OFS_CMD, 32'h1);
		waitState(3'h4);
		bus(1'b1, OFS_COUNT, 32'h0, v); chk(v, 32'h1);
		bus(1'b1, OFS_IRQ_STAT, 32'h0, v); chk(v, 32'hF);
		wr(OFS_CTRL, 32'h5);
		wr(OFS_CMD, 32'h1);
		repeat (70) @(posedge core_clk);
		bus(1'b1, OFS_STATUS, 32'h0, v); chk({29'h0, v[7:5]}, 32'h1);
		differ <= 1'b0;
		waitState(3'h4);
		bus(1'b1, OFS_IRQ_STAT, 32'h0, v); chk(v, 32'h9);
	endtask : tCompare
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		tResetRegs();
		tLimit();
		tHang();
		tClock();
		tCompare();
		test_done();
	end
endmodule : tb_top
